/* File: hdl/weld_io.sv */
// Programmable contact inputs and status outputs of the weld controller
`timescale 1ns/1ps

// Behaviour
// - Thermal/flow input open stops sequence, error 15
// - Second stage holds before weld until closed
// - Back step tap decrements successive schedule
// - Back step held one second returns first
// - Edit lock closed refuses configuration writes
// - Error reset closure clears active error
// - Head lock freezes valves until escape
// - Wait-here 99 cycles ends on escape
// - Interlock holds before weld, timeout error 16
// - Pressure switch holds weld, timeout error 12
// - Part counter reset closure zeroes part count
// - Momentary retraction closure toggles retraction output
// - Maintained retraction output follows closed input
// - Weld without retraction active raises error 61
// - External schedule is weighted select sum
// - Stepper reset closure zeroes stepper count
// - Weld counter reset closure zeroes weld count
// - End of sequence output pulses 0.5 s
// - Water saver output ends after set time
// - Current error output on window violation
// - Any error and major error outputs
// - Step end output when count completes
// - Contactor error output on error 13
module weld_io
    import weld_io_pkg::*;
#(
    parameter int DEB_CYC = DEBOUNCE_CYCLES,
    parameter int HOLD_CYC = BACKSTEP_HOLD_CYCLES,
    parameter int EOS_CYC = EOS_CYCLES,
    parameter int MS_CYC = MS_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Contact closures, high while closed to the common return
    input wire logic first_stage_initiate_a,
    input wire logic first_stage_initiate_b,
    input wire logic prog_input_1,
    input wire logic prog_input_2,
    input wire logic prog_input_3,
    input wire logic prog_input_4,
    input wire logic prog_input_5,
    input wire logic prog_input_6,
    // Programmable outputs
    output logic prog_output_1,
    output logic prog_output_2,
    output logic prog_output_3,
    output logic prog_output_4,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Weld sequencer side
    input wire seq_in_s seq,
    output ctl_out_s ctl
);

    localparam int NC = 8;

    logic [NC-1:0] raw;
    logic [NC-1:0] lvl;
    logic [NC-1:0] lvl_d;
    logic [NC-1:0] rise;
    logic [29:0] in_map;
    logic [15:0] out_map;
    logic [MODE_W-1:0] mode;
    logic [31:0] time_cfg;
    logic [15:0] step_target;
    logic [7:0] err_code;
    logic err_major;
    logic [5:0] sched;
    logic retract;
    logic freeze;
    logic esc_break;
    logic [15:0] part_cnt;
    logic [15:0] weld_cnt;
    logic [15:0] step_cnt;
    logic [31:0] eos_cnt;
    logic [15:0] ws_ms;
    logic [31:0] ms_div;
    logic ms_tick;
    logic [31:0] bs_cnt;
    logic bs_long_done;
    logic [15:0] wait_ms;
    gate_e gate;
    logic [3:0] po;

    assign raw = {first_stage_initiate_b, first_stage_initiate_a, prog_input_6,
        prog_input_5, prog_input_4, prog_input_3, prog_input_2, prog_input_1};

    // Long debounce trades closure latency for immunity to weld-induced noise
    for (genvar i = 0; i < NC; i++)
    begin : g_contact
        logic [1:0] sync;
        logic [31:0] cnt;
        logic level;
        always_ff @(posedge sys_clk or negedge rstn)
        begin
            if (!rstn)
            begin
                sync <= 2'h0;
                cnt <= 32'h0;
                level <= 1'b0;
            end
            else
            begin
                sync <= {sync[0], raw[i]};
                if (sync[1] == level)
                    cnt <= 32'h0;
                else if (cnt >= 32'(DEB_CYC - 1))
                begin
                    level <= sync[1];
                    cnt <= 32'h0;
                end
                else
                    cnt <= cnt + 32'h1;
            end
        end
        assign lvl[i] = level;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            lvl_d <= '0;
        else
            lvl_d <= lvl;
    end

    assign rise = lvl & ~lvl_d;

    function automatic logic hit(input logic [29:0] m, input logic [5:0] v, input in_func_e f);
        logic r;
        r = 1'b0;
        for (int k = 0; k < 6; k++)
            r = r | (v[k] & (m[k*IN_FW +: IN_FW] == f));
        return r;
    endfunction

    logic assigned_thermal;
    logic thermal_ok;
    logic permits;
    logic interlock_ok;
    logic locked;
    logic bs_held;
    logic bs_fall;
    logic [3:0] sel;
    logic initiate;
    logic [5:0] cl;
    logic [5:0] cr;
    logic [5:0] ones;

    assign cl = lvl[5:0];
    assign cr = rise[5:0];
    assign ones = 6'h3F;
    assign initiate = lvl[6] | lvl[7];
    assign assigned_thermal = hit(in_map, ones, F_THERMAL);
    assign thermal_ok = !assigned_thermal || hit(in_map, cl, F_THERMAL);
    assign interlock_ok = !hit(in_map, ones, F_INTERLOCK) || hit(in_map, cl, F_INTERLOCK);
    assign permits = thermal_ok && interlock_ok
        && (!hit(in_map, ones, F_STAGE2) || hit(in_map, cl, F_STAGE2))
        && (!hit(in_map, ones, F_PRESSURE) || hit(in_map, cl, F_PRESSURE));
    assign locked = hit(in_map, cl, F_EDITLOCK);
    assign bs_held = hit(in_map, cl, F_BACKSTEP);
    assign bs_fall = hit(in_map, lvl_d[5:0] & ~cl, F_BACKSTEP);
    assign sel = {hit(in_map, cl, F_SEL8), hit(in_map, cl, F_SEL4),
        hit(in_map, cl, F_SEL2), hit(in_map, cl, F_SEL1)};

    // Millisecond time base
    assign ms_tick = (ms_div >= 32'(MS_CYC - 1));

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ms_div <= 32'h0;
        else if (ms_tick)
            ms_div <= 32'h0;
        else
            ms_div <= ms_div + 32'h1;
    end

    // Weld gate: holds the sequence ahead of the weld interval
    logic timeout;
    logic raise_int;
    logic [7:0] raise_code;
    logic retr_bad;

    assign retr_bad = (retr_e'(mode[MODE_RETR_LSB +: 2]) != RETR_OFF) && !retract;
    assign timeout = (time_cfg[31:16] != 16'h0) && (wait_ms >= time_cfg[31:16]);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gate <= G_IDLE;
            wait_ms <= 16'h0;
        end
        else
        begin
            unique case (gate)
                G_IDLE:
                begin
                    wait_ms <= 16'h0;
                    if (seq.at_weld)
                        gate <= retr_bad ? G_BLOCK : G_WAIT;
                end
                G_WAIT:
                begin
                    if (ms_tick)
                        wait_ms <= wait_ms + 16'h1;
                    if (!seq.at_weld)
                        gate <= G_IDLE;
                    else if (!thermal_ok)
                        gate <= G_BLOCK;
                    else if (permits)
                        gate <= G_GO;
                    else if (timeout)
                        gate <= G_BLOCK;
                end
                G_GO:
                begin
                    if (!seq.at_weld)
                        gate <= G_IDLE;
                    else if (!thermal_ok)
                        gate <= G_BLOCK;
                end
                G_BLOCK:
                begin
                    if (!seq.at_weld)
                        gate <= G_IDLE;
                end
            endcase
        end
    end

    always_comb
    begin
        raise_int = 1'b0;
        raise_code = 8'h00;
        if (seq.seq_active && !thermal_ok)
        begin
            raise_int = 1'b1;
            raise_code = ER_THERMAL;
        end
        else if (gate == G_IDLE && seq.at_weld && retr_bad)
        begin
            raise_int = 1'b1;
            raise_code = ER_RETRACT;
        end
        else if (gate == G_WAIT && seq.at_weld && !permits && timeout)
        begin
            raise_int = 1'b1;
            raise_code = interlock_ok ? ER_PRESSURE : ER_INTERLOCK;
        end
    end

    // Error latch: a new error in the reset cycle wins
    logic raise_any;
    assign raise_any = raise_int || seq.err_valid;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            err_code <= 8'h00;
            err_major <= 1'b0;
        end
        else if (raise_int)
        begin
            err_code <= raise_code;
            err_major <= 1'b0;
        end
        else if (seq.err_valid)
        begin
            err_code <= seq.err_code;
            err_major <= seq.err_major;
        end
        else if (hit(in_map, cr, F_ERRRST))
        begin
            err_code <= 8'h00;
            err_major <= 1'b0;
        end
    end

    // Head lock and wait-here escape
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            freeze <= 1'b0;
            esc_break <= 1'b0;
        end
        else
        begin
            if (mode[MODE_HOLD_VALVES_ON_FAULT] && raise_any)
                freeze <= 1'b1;
            else if (hit(in_map, cr, F_ESCAPE))
                freeze <= 1'b0;
            esc_break <= hit(in_map, cr, F_ESCAPE) && mode[MODE_BEAT_WAIT]
                && mode[MODE_CYCLE_WAIT] && seq.hold_99;
        end
    end

    // Back step: short tap steps back, one second hold returns to first
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bs_cnt <= 32'h0;
            bs_long_done <= 1'b0;
        end
        else if (!bs_held)
        begin
            bs_cnt <= 32'h0;
            bs_long_done <= 1'b0;
        end
        else if (bs_cnt < 32'(HOLD_CYC - 1))
            bs_cnt <= bs_cnt + 32'h1;
        else
            bs_long_done <= 1'b1;
    end

    logic bs_long;
    assign bs_long = bs_held && !bs_long_done && (bs_cnt >= 32'(HOLD_CYC - 1));

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            sched <= 6'h00;
        else if (seq.chain_valid)
            sched <= seq.chain_sched;
        else if (mode[MODE_SUCCESSIVE] && bs_long)
            sched <= seq.first_sched;
        else if (mode[MODE_SUCCESSIVE] && bs_fall && !bs_long_done && sched != 6'h00)
            sched <= sched - 6'h01;
    end

    // Retraction
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            retract <= 1'b0;
        else
        begin
            unique case (retr_e'(mode[MODE_RETR_LSB +: 2]))
                RETR_MOM:
                begin
                    if (hit(in_map, cr, F_RETRACT))
                        retract <= !retract;
                end
                RETR_MAINT: retract <= hit(in_map, cl, F_RETRACT);
                default: retract <= 1'b0;
            endcase
        end
    end

    // Counters; an increment in the reset cycle counts from zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            part_cnt <= 16'h0;
            weld_cnt <= 16'h0;
            step_cnt <= 16'h0;
        end
        else
        begin
            part_cnt <= (hit(in_map, cr, F_PART_COUNTER_RESET) ? 16'h0 : part_cnt) + {15'h0, seq.part_done};
            weld_cnt <= (hit(in_map, cr, F_WELD_COUNTER_RESET) ? 16'h0 : weld_cnt) + {15'h0, seq.weld_done};
            step_cnt <= (hit(in_map, cr, F_STEPRST) ? 16'h0 : step_cnt) + {15'h0, seq.weld_done};
        end
    end

    // End of sequence pulse and water saver timer
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            eos_cnt <= 32'h0;
            ws_ms <= 16'h0;
        end
        else
        begin
            if (seq.seq_done)
                eos_cnt <= 32'(EOS_CYC);
            else if (eos_cnt != 32'h0)
                eos_cnt <= eos_cnt - 32'h1;
            if (initiate || seq.weld_done)
                ws_ms <= time_cfg[15:0];
            else if (ms_tick && ws_ms != 16'h0)
                ws_ms <= ws_ms - 16'h1;
        end
    end

    // Output function selection
    logic [15:0] ofv;
    logic any_err;
    assign any_err = (err_code != 8'h00);

    always_comb
    begin
        ofv = 16'h0;
        ofv[O_ANY_ERR] = any_err;
        ofv[O_RETRACT] = retract;
        ofv[O_FORCE_ERR] = (err_code == ER_FORCE);
        ofv[O_MAJOR] = any_err && err_major;
        ofv[O_AVC] = (err_code == ER_AVC);
        ofv[O_CONTACTOR] = (err_code == ER_CONTACTOR);
        ofv[O_STEP_END] = mode[MODE_STEP_EN] && step_target != 16'h0 && step_cnt >= step_target;
        ofv[O_EOS] = (eos_cnt != 32'h0);
        ofv[O_CURRENT] = seq.current_bad || (err_code >= ER_CUR_FIRST && err_code <= ER_CUR_LAST);
        ofv[O_COUNT_END] = (err_code == ER_COUNT_END);
        ofv[O_WATER] = initiate || (ws_ms != 16'h0);
        ofv[O_INTERLOCK] = (err_code == ER_INTERLOCK_REQ);
    end

    for (genvar j = 0; j < 4; j++)
    begin : g_out
        always_ff @(posedge sys_clk or negedge rstn)
        begin
            if (!rstn)
                po[j] <= 1'b0;
            else
                po[j] <= ofv[out_map[j*OUT_FW +: OUT_FW]];
        end
    end

    assign prog_output_1 = po[0];
    assign prog_output_2 = po[1];
    assign prog_output_3 = po[2];
    assign prog_output_4 = po[3];

    // Register writes; configuration is frozen while edit lock is closed
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            in_map <= IN_MAP_RST;
            out_map <= OUT_MAP_RST;
            mode <= MODE_RST;
            time_cfg <= TIME_RST;
            step_target <= STEP_TARGET_RST;
        end
        else if (wr && !locked)
        begin
            unique case (addr)
                REG_IN_MAP: in_map <= wdata[29:0];
                REG_OUT_MAP: out_map <= wdata[15:0];
                REG_MODE: mode <= wdata[MODE_W-1:0];
                REG_TIME: time_cfg <= wdata;
                REG_STEP: step_target <= wdata[15:0];
                default: ;
            endcase
        end
    end

    logic [5:0] act_sched;
    assign act_sched = mode[MODE_SCHED_EXT] ? {2'b00, sel} : sched;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= 32'h0;
        else if (rd)
        begin
            unique case (addr)
                REG_IN_MAP: rdata <= {2'b00, in_map};
                REG_OUT_MAP: rdata <= {16'h0, out_map};
                REG_MODE: rdata <= {24'h0, mode};
                REG_TIME: rdata <= time_cfg;
                REG_STATUS: rdata <= {6'h0, gate, 2'b00, act_sched, 5'h0, !locked, retract, err_major, err_code};
                REG_COUNT: rdata <= {weld_cnt, part_cnt};
                REG_STEP: rdata <= {step_cnt, step_target};
                default: rdata <= 32'h0;
            endcase
        end
        else
            rdata <= 32'h0;
    end

    assign ctl.weld_go = (gate == G_GO);
    assign ctl.hold_weld = (gate == G_WAIT);
    assign ctl.valve_freeze = freeze;
    assign ctl.escape_break = esc_break;
    assign ctl.edit_allowed = !locked;
    assign ctl.retract_active = retract;
    assign ctl.active_sched = act_sched;
    assign ctl.error_code = err_code;
    assign ctl.error_major = err_major;

endmodule

/* File: hdl/weld_io_pkg.sv */
// Constants, encodings and carrier types for the weld controller programmable I/O
package weld_io_pkg;

    localparam int CLK_HZ = 50_000_000;
    localparam int DEBOUNCE_MS = 10;
    localparam int BACKSTEP_HOLD_S = 1;
    localparam int EOS_PULSE_MS = 500;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int DEBOUNCE_CYCLES = MS_CYCLES * DEBOUNCE_MS;
    localparam int BACKSTEP_HOLD_CYCLES = CLK_HZ * BACKSTEP_HOLD_S;
    localparam int EOS_CYCLES = MS_CYCLES * EOS_PULSE_MS;

    localparam logic [7:0] REG_IN_MAP = 8'h00;
    localparam logic [7:0] REG_OUT_MAP = 8'h04;
    localparam logic [7:0] REG_MODE = 8'h08;
    localparam logic [7:0] REG_TIME = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_COUNT = 8'h14;
    localparam logic [7:0] REG_STEP = 8'h18;

    localparam int IN_FW = 5;
    localparam int OUT_FW = 4;
    localparam int MODE_SCHED_EXT = 0;
    localparam int MODE_RETR_LSB = 1;
    localparam int MODE_HOLD_VALVES_ON_FAULT = 3;
    localparam int MODE_SUCCESSIVE = 4;
    localparam int MODE_BEAT_WAIT = 5;
    localparam int MODE_CYCLE_WAIT = 6;
    localparam int MODE_STEP_EN = 7;
    localparam int MODE_W = 8;
    localparam int ST_MAJOR = 8;
    localparam int ST_RETRACT = 9;
    localparam int ST_EDIT_OK = 10;
    localparam int ST_SCHED_LSB = 16;
    localparam int ST_GATE_LSB = 24;

    typedef enum logic [4:0] {
        F_NONE = 5'h00, F_THERMAL = 5'h01, F_STAGE2 = 5'h02, F_BACKSTEP = 5'h03,
        F_PART_COUNTER_RESET = 5'h04, F_EDITLOCK = 5'h05, F_PRESSURE = 5'h06, F_INTERLOCK = 5'h07,
        F_WELD_COUNTER_RESET = 5'h08, F_ERRRST = 5'h09, F_SEL1 = 5'h0A, F_SEL2 = 5'h0B,
        F_SEL4 = 5'h0C, F_SEL8 = 5'h0D, F_STEPRST = 5'h0E, F_RETRACT = 5'h0F,
        F_ESCAPE = 5'h10
    } in_func_e;

    typedef enum logic [3:0] {
        O_NONE = 4'h0, O_ANY_ERR = 4'h1, O_RETRACT = 4'h2, O_FORCE_ERR = 4'h3,
        O_MAJOR = 4'h4, O_AVC = 4'h5, O_CONTACTOR = 4'h6, O_STEP_END = 4'h7,
        O_EOS = 4'h8, O_CURRENT = 4'h9, O_COUNT_END = 4'hA, O_WATER = 4'hB,
        O_INTERLOCK = 4'hC
    } out_func_e;

    typedef enum logic [1:0] {
        RETR_OFF = 2'b00, RETR_MOM = 2'b01, RETR_MAINT = 2'b10
    } retr_e;

    typedef enum logic [1:0] {
        G_IDLE = 2'b00, G_WAIT = 2'b01, G_GO = 2'b10, G_BLOCK = 2'b11
    } gate_e;

    localparam logic [29:0] IN_MAP_RST = {F_ESCAPE, F_BACKSTEP, F_INTERLOCK,
        F_ERRRST, F_EDITLOCK, F_THERMAL};
    localparam logic [15:0] OUT_MAP_RST = {O_STEP_END, O_CURRENT, O_AVC, O_ANY_ERR};
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [31:0] TIME_RST = 32'h03E8_07D0;
    localparam logic [15:0] STEP_TARGET_RST = 16'h0000;

    localparam logic [7:0] ER_PRESSURE = 8'h0C;
    localparam logic [7:0] ER_CONTACTOR = 8'h0D;
    localparam logic [7:0] ER_THERMAL = 8'h0F;
    localparam logic [7:0] ER_INTERLOCK = 8'h10;
    localparam logic [7:0] ER_CUR_FIRST = 8'h13;
    localparam logic [7:0] ER_CUR_LAST = 8'h16;
    localparam logic [7:0] ER_COUNT_END = 8'h19;
    localparam logic [7:0] ER_AVC = 8'h20;
    localparam logic [7:0] ER_FORCE = 8'h3C;
    localparam logic [7:0] ER_RETRACT = 8'h3D;
    localparam logic [7:0] ER_INTERLOCK_REQ = 8'h40;

    typedef struct packed {
        logic at_weld;
        logic seq_active;
        logic seq_done;
        logic weld_done;
        logic part_done;
        logic hold_99;
        logic chain_valid;
        logic [5:0] chain_sched;
        logic [5:0] first_sched;
        logic current_bad;
        logic err_valid;
        logic [7:0] err_code;
        logic err_major;
    } seq_in_s;

    typedef struct packed {
        logic weld_go;
        logic hold_weld;
        logic valve_freeze;
        logic escape_break;
        logic edit_allowed;
        logic retract_active;
        logic [5:0] active_sched;
        logic [7:0] error_code;
        logic error_major;
    } ctl_out_s;

endpackage

/* File: verif/contact_bank.sv */
// Contact closures that chatter briefly on every change of position
`timescale 1ns/1ps
module contact_bank (
    // Clock for chatter timing
    input wire logic sys_clk,
    // Settled positions asked for, and the contact levels seen
    input wire logic [5:0] want,
    output logic [5:0] pin
);
    logic [5:0] last = 6'h00;
    logic [5:0] diff = 6'h00;
    int chat = 0;
    initial pin = 6'h00;
    // Chatter is shorter than the debounce window, so it must never reach a function
    always @(posedge sys_clk)
    begin
        if (want != last)
        begin
            last <= want;
            diff <= want ^ last;
            chat <= 3;
            pin <= want;
        end
        else if (chat > 0)
        begin
            chat <= chat - 1;
            pin <= pin ^ diff;
        end
        else
            pin <= last;
    end
endmodule

/* File: verif/weld_io_chk.sv */
// Port checks of the weld programmable I/O block
`timescale 1ns/1ps
module weld_io_chk
    import weld_io_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register read side
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Sequencer side
    input wire seq_in_s seq,
    input wire ctl_out_s ctl
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_new_req;
        !seq.at_weld ##1 seq.at_weld;
    endsequence
    sequence s_wait_go;
        ctl.hold_weld ##1 ctl.weld_go;
    endsequence
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    chk_req_taken: assert property (s_new_req |=> ctl.hold_weld || ctl.error_code == ER_RETRACT)
        else $error("weld request neither waited nor refused");
    chk_go_after_wait: assert property ($rose(ctl.weld_go) |-> $past(ctl.hold_weld))
        else $error("weld started without holding first");
    chk_go_drop: assert property (ctl.weld_go && !seq.at_weld |=> !ctl.weld_go)
        else $error("weld go stayed after request dropped");
    chk_esc_pulse: assert property (ctl.escape_break |=> !ctl.escape_break)
        else $error("escape break longer than one cycle");
    chk_esc_cause: assert property (ctl.escape_break |-> $past(seq.hold_99))
        else $error("escape break outside a wait-here interval");
    chk_freeze_cause: assert property ($rose(ctl.valve_freeze) |-> ctl.error_code != 8'h00)
        else $error("valves frozen with no error");
    chk_major_cause: assert property ($rose(ctl.error_major) |-> $past(seq.err_valid && seq.err_major))
        else $error("major error without a major error event");
    cover property (s_wait_go);
endmodule
bind weld_io weld_io_chk i_weld_io_chk (.sys_clk(sys_clk), .rstn(rstn), .rd(rd), .rdata(rdata), .seq(seq),
    .ctl(ctl));

/* File: verif/weld_io_tb.sv */
// Self-checking bench of the weld programmable I/O block
`timescale 1ns/1ps
module weld_io_tb;
    import weld_io_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] want = 6'h00;
    logic fsi = 1'b0;
    logic [5:0] pins;
    logic [3:0] o;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] v;
    seq_in_s sq = '0;
    ctl_out_s ctl;
    int errors = 0;
    int cmp_count = 0;
    int breaks = 0;
    int n;
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (ctl.escape_break === 1'b1)
            breaks++;
    weld_io #(.DEB_CYC(4), .HOLD_CYC(50), .EOS_CYC(20), .MS_CYC(10)) i_weld_io (
        .sys_clk(sys_clk), .rstn(rstn), .first_stage_initiate_a(fsi), .first_stage_initiate_b(1'b0),
        .prog_input_1(pins[0]), .prog_input_2(pins[1]), .prog_input_3(pins[2]),
        .prog_input_4(pins[3]), .prog_input_5(pins[4]), .prog_input_6(pins[5]),
        .prog_output_1(o[0]), .prog_output_2(o[1]), .prog_output_3(o[2]), .prog_output_4(o[3]),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .seq(sq), .ctl(ctl));
    contact_bank i_contact_bank (.sys_clk(sys_clk), .want(want), .pin(pins));
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test;
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Long enough for chatter, sync and debounce to settle
    task automatic set_in(input logic [5:0] w);
        want <= w;
        cyc(16);
    endtask
    function automatic logic [5:0] sel_sum(input logic [3:0] b);
        return 6'(b[0]) + 6'(b[1]) * 6'd2 + 6'(b[2]) * 6'd4 + 6'(b[3]) * 6'd8;
    endfunction
    initial
    begin
        cyc(30000);
        errors++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(72));
        cyc(16);
        rstn <= 1'b1;
        rreg(REG_IN_MAP);
        chk("in_map", v, {2'b00, IN_MAP_RST});
        rreg(REG_OUT_MAP);
        chk("out_map", v, {16'h0000, OUT_MAP_RST});
        rreg(REG_TIME);
        chk("time", v, TIME_RST);
        rreg(8'h1C);
        chk("unmapped", v, 32'h0);
        wreg(REG_IN_MAP, {2'b00, F_ERRRST, F_RETRACT, F_SEL8, F_SEL4, F_SEL2, F_SEL1});
        wreg(REG_MODE, 32'h1);
        for (n = 0; n < 6; n++)
        begin
            v = (n == 0) ? 32'hF : $urandom;
            set_in({2'b00, v[3:0]});
            chk("sched", ctl.active_sched, sel_sum(v[3:0]));
        end
        set_in(6'h00);
        sq.err_code <= 8'h21;
        sq.err_major <= 1'b1;
        sq.err_valid <= 1'b1;
        sq.current_bad <= 1'b1;
        cyc(1);
        sq.err_valid <= 1'b0;
        cyc(3);
        chk("major", ctl.error_major, 1);
        chk("any_err", o[0], 1);
        chk("cur_err", o[2], 1);
        sq.current_bad <= 1'b0;
        set_in(6'h20);
        chk("err_rst", ctl.error_code, 0);
        set_in(6'h00);
        wreg(REG_OUT_MAP, {16'h0000, O_STEP_END, O_CURRENT, O_EOS, O_ANY_ERR});
        sq.seq_done <= 1'b1;
        cyc(1);
        sq.seq_done <= 1'b0;
        n = 0;
        while (o[1] !== 1'b1 && n < 10)
        begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        while (o[1] === 1'b1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("eos_len", n, 20);
        wreg(REG_IN_MAP, {2'b00, F_ESCAPE, F_RETRACT, F_EDITLOCK, F_STEPRST, F_WELD_COUNTER_RESET, F_PART_COUNTER_RESET});
        wreg(REG_MODE, 32'h8A);
        wreg(REG_STEP, 32'h3);
        n = 3 + $urandom % 4;
        repeat (n)
        begin
            @(posedge sys_clk);
            sq.weld_done <= 1'b1;
            sq.part_done <= 1'b1;
            @(posedge sys_clk);
            sq.weld_done <= 1'b0;
            sq.part_done <= 1'b0;
        end
        cyc(3);
        chk("step_end", o[3], 1);
        set_in(6'h01);
        set_in(6'h00);
        rreg(REG_COUNT);
        chk("part_rst", v, {n[15:0], 16'h0000});
        set_in(6'h02);
        set_in(6'h00);
        rreg(REG_COUNT);
        chk("weld_rst", v, 32'h0);
        set_in(6'h04);
        set_in(6'h00);
        rreg(REG_STEP);
        chk("step_rst", v, 32'h3);
        sq.at_weld <= 1'b1;
        cyc(3);
        chk("no_retract", ctl.error_code, ER_RETRACT);
        chk("freeze", ctl.valve_freeze, 1);
        sq.at_weld <= 1'b0;
        set_in(6'h20);
        chk("escape", ctl.valve_freeze, 0);
        set_in(6'h10);
        set_in(6'h00);
        chk("retr_on", ctl.retract_active, 1);
        sq.at_weld <= 1'b1;
        cyc(4);
        chk("weld_go", ctl.weld_go, 1);
        sq.at_weld <= 1'b0;
        set_in(6'h10);
        set_in(6'h00);
        chk("retr_off", ctl.retract_active, 0);
        wreg(REG_MODE, 32'h84);
        set_in(6'h10);
        chk("maint", ctl.retract_active, 1);
        set_in(6'h08);
        chk("maint_off", ctl.retract_active, 0);
        chk("locked", ctl.edit_allowed, 0);
        wreg(REG_MODE, 32'h60);
        rreg(REG_MODE);
        chk("lock_mode", v, 32'h84);
        set_in(6'h00);
        wreg(REG_MODE, 32'h60);
        // Short saver time so the output must drop well inside the wait
        wreg(REG_TIME, 32'h3);
        wreg(REG_OUT_MAP, {16'h0000, O_WATER, O_CURRENT, O_EOS, O_ANY_ERR});
        fsi <= 1'b1;
        cyc(16);
        fsi <= 1'b0;
        cyc(12);
        chk("water_on", o[3], 1);
        cyc(50);
        chk("water_off", o[3], 0);
        sq.hold_99 <= 1'b1;
        set_in(6'h20);
        chk("break", breaks, 1);
        end_of_test();
    end
endmodule
